// ### logic/sfd_pkg.sv
// Package: opcodes, command classes and clock-rate limits of the decoder
`default_nettype none
package sfd_pkg;

   // ********************************************************************
   // Command classes
   // ********************************************************************
   typedef enum logic [3:0] {
      SFD_CLS_NONE     = 4'h0,
      SFD_CLS_READ     = 4'h1,
      SFD_CLS_PROGRAM  = 4'h2,
      SFD_CLS_ERASE    = 4'h3,
      SFD_CLS_SUSPEND  = 4'h4,
      SFD_CLS_REGACC   = 4'h5,
      SFD_CLS_PROTECT  = 4'h6,
      SFD_CLS_IDENT    = 4'h7,
      SFD_CLS_RESET    = 4'h8
   } sfd_class_e;

   // ********************************************************************
   // Opcodes
   // ********************************************************************
   localparam logic [7:0] OP_WRITE_STATUS_CONFIG       = 8'h01,
                          OP_PAGE_PROGRAM              = 8'h02,
                          OP_NORMAL_READ               = 8'h03;
   localparam logic [7:0] OP_WRITE_DISABLE             = 8'h04,
                          OP_STATUS1_READ              = 8'h05,
                          OP_WRITE_ENABLE              = 8'h06;
   localparam logic [7:0] OP_STATUS2_READ              = 8'h07,
                          OP_QUICK_FETCH               = 8'h0B,
                          OP_QUICK_FETCH_LONG_ADDR     = 8'h0C;
   localparam logic [7:0] OP_PAGE_PROGRAM_LONG_ADDR    = 8'h12,
                          OP_NORMAL_READ_LONG_ADDR     = 8'h13,
                          OP_BOOT_REG_READ             = 8'h14;
   localparam logic [7:0] OP_BOOT_REG_WRITE            = 8'h15,
                          OP_BANK_REG_READ             = 8'h16,
                          OP_BANK_REG_WRITE            = 8'h17;
   localparam logic [7:0] OP_ECC_READ                  = 8'h18,
                          OP_PARAM_SECTOR_WIPE         = 8'h20,
                          OP_PARAM_SECTOR_WIPE_LONG    = 8'h21;
   localparam logic [7:0] OP_SECT_PROT_READ            = 8'h2B,
                          OP_SECT_PROT_PROGRAM         = 8'h2F,
                          OP_CLEAR_STATUS              = 8'h30;
   localparam logic [7:0] OP_QUAD_PAGE_PROGRAM         = 8'h32,
                          OP_QUAD_PAGE_PROGRAM_LONG    = 8'h34,
                          OP_CONFIG1_READ              = 8'h35;
   localparam logic [7:0] OP_QUAD_PAGE_PROGRAM_ALT     = 8'h38,
                          OP_LEARNING_PATTERN_READBACK = 8'h41,
                          OP_OTP_PROGRAM               = 8'h42;
   localparam logic [7:0] OP_NONVOLATILE_LEARNING_PROG = 8'h43,
                          OP_VOLATILE_LEARNING_WRITE   = 8'h4A,
                          OP_OTP_READ                  = 8'h4B;
   localparam logic [7:0] OP_BULK_WIPE                 = 8'h60,
                          OP_QUAD_OUTPUT_READ          = 8'h6B,
                          OP_QUAD_OUTPUT_READ_LONG     = 8'h6C;
   localparam logic [7:0] OP_ERASE_SUSPEND             = 8'h75,
                          OP_ERASE_RESUME              = 8'h7A,
                          OP_PROGRAM_SUSPEND           = 8'h85;
   localparam logic [7:0] OP_PROGRAM_RESUME            = 8'h8A,
                          OP_LEGACY_MAKER_SIGNATURE    = 8'h90,
                          OP_IDENTIFICATION_READ       = 8'h9F;
   localparam logic [7:0] OP_MULTI_IO_PERF_RESERVED    = 8'hA3,
                          OP_LOCK_BIT_WRITE            = 8'hA6,
                          OP_LOCK_BIT_READ             = 8'hA7;
   localparam logic [7:0] OP_ELECTRONIC_SIG_READ       = 8'hAB,
                          OP_BANK_REGISTER_ACCESS      = 8'hB9,
                          OP_BULK_WIPE_ALT             = 8'hC7;
   localparam logic [7:0] OP_BIG_BLOCK_WIPE            = 8'hD8,
                          OP_BIG_BLOCK_WIPE_LONG_ADDR  = 8'hDC,
                          OP_DYN_PROT_READ             = 8'hE0;
   localparam logic [7:0] OP_DYN_PROT_WRITE            = 8'hE1,
                          OP_PERS_PROT_READ            = 8'hE2,
                          OP_PERS_PROT_PROGRAM         = 8'hE3;
   localparam logic [7:0] OP_PERS_PROT_ERASE           = 8'hE4,
                          OP_RESERVED_E5               = 8'hE5,
                          OP_RESERVED_E6               = 8'hE6;
   localparam logic [7:0] OP_PASSWORD_READ             = 8'hE7,
                          OP_PASSWORD_PROGRAM          = 8'hE8,
                          OP_PASSWORD_UNLOCK           = 8'hE9;
   localparam logic [7:0] OP_QUAD_IO_READ              = 8'hEB,
                          OP_QUAD_IO_READ_LONG_ADDR    = 8'hEC,
                          OP_DOUBLE_RATE_QUAD_IO_READ  = 8'hED;
   localparam logic [7:0] OP_DOUBLE_RATE_QUAD_IO_LONG  = 8'hEE,
                          OP_SOFTWARE_RESET            = 8'hF0,
                          OP_CONTINUOUS_MODE_EXIT      = 8'hFF;

   // ********************************************************************
   // Serial clock limits in MHz, and bit counts
   // ********************************************************************
   localparam logic [7:0] RATE_MHZ_133 = 8'h85;
   localparam logic [7:0] RATE_MHZ_104 = 8'h68;
   localparam logic [7:0] RATE_MHZ_80  = 8'h50;
   localparam logic [7:0] RATE_MHZ_50  = 8'h32;
   localparam logic [2:0] OPC_LAST_BIT = 3'h7;
   localparam logic [2:0] EXIT_LAST_CYC = 3'h7;
   localparam logic [2:0] CNT_ZERO     = 3'h0;
   localparam logic [2:0] CNT_STEP     = 3'h1;

endpackage : sfd_pkg
`default_nettype wire

// ### logic/sfd_dec_if.sv
// Interface: opcode lookup request and its decoded answer
`default_nettype none
interface sfd_dec_if;
   import sfd_pkg::*;
   logic [7:0] opcode;
   sfd_class_e cls;
   logic       known;
   logic       long_addr;
   logic       nv_pe;
   logic [7:0] rate_mhz;
   modport req (output opcode, input cls, known, long_addr, nv_pe, rate_mhz);
   modport dec (input opcode, output cls, known, long_addr, nv_pe, rate_mhz);
endinterface : sfd_dec_if
`default_nettype wire

// ### logic/sfd_op_table.sv
// Opcode lookup table: class, address form, rate limit per opcode
`default_nettype none
module sfd_op_table (
   sfd_dec_if.dec dif            // Lookup request and answer
);
   import sfd_pkg::*;

   always_comb begin
      dif.cls       = SFD_CLS_NONE;
      dif.known     = 1'b1;
      dif.long_addr = 1'b0;
      dif.nv_pe     = 1'b0;
      dif.rate_mhz  = RATE_MHZ_133;
      case (dif.opcode)
         OP_NORMAL_READ, OP_ECC_READ, OP_QUICK_FETCH: begin
            dif.cls = SFD_CLS_READ;
         end
         OP_QUICK_FETCH_LONG_ADDR: begin
            dif.cls       = SFD_CLS_READ;
            dif.long_addr = 1'b1;
         end
         OP_NORMAL_READ_LONG_ADDR: begin
            dif.cls       = SFD_CLS_READ;
            dif.long_addr = 1'b1;
         end
         OP_QUAD_OUTPUT_READ, OP_QUAD_IO_READ: begin
            dif.cls      = SFD_CLS_READ;
            dif.rate_mhz = RATE_MHZ_104;
         end
         OP_QUAD_OUTPUT_READ_LONG, OP_QUAD_IO_READ_LONG_ADDR: begin
            dif.cls       = SFD_CLS_READ;
            dif.long_addr = 1'b1;
            dif.rate_mhz  = RATE_MHZ_104;
         end
         OP_DOUBLE_RATE_QUAD_IO_READ: begin
            dif.cls      = SFD_CLS_READ;
            dif.rate_mhz = RATE_MHZ_80;
         end
         OP_DOUBLE_RATE_QUAD_IO_LONG: begin
            dif.cls       = SFD_CLS_READ;
            dif.long_addr = 1'b1;
            dif.rate_mhz  = RATE_MHZ_80;
         end
         OP_PAGE_PROGRAM: dif.cls = SFD_CLS_PROGRAM;
         OP_PAGE_PROGRAM_LONG_ADDR: begin
            dif.cls       = SFD_CLS_PROGRAM;
            dif.long_addr = 1'b1;
         end
         OP_QUAD_PAGE_PROGRAM, OP_QUAD_PAGE_PROGRAM_ALT: begin
            dif.cls      = SFD_CLS_PROGRAM;
            dif.rate_mhz = RATE_MHZ_80;
         end
         OP_QUAD_PAGE_PROGRAM_LONG: begin
            dif.cls       = SFD_CLS_PROGRAM;
            dif.long_addr = 1'b1;
            dif.rate_mhz  = RATE_MHZ_80;
         end
         OP_PARAM_SECTOR_WIPE, OP_BIG_BLOCK_WIPE: begin
            dif.cls = SFD_CLS_ERASE;
         end
         OP_PARAM_SECTOR_WIPE_LONG, OP_BIG_BLOCK_WIPE_LONG_ADDR: begin
            dif.cls       = SFD_CLS_ERASE;
            dif.long_addr = 1'b1;
         end
         OP_BULK_WIPE, OP_BULK_WIPE_ALT: dif.cls = SFD_CLS_ERASE;
         OP_ERASE_SUSPEND, OP_ERASE_RESUME, OP_PROGRAM_SUSPEND,
         OP_PROGRAM_RESUME: dif.cls = SFD_CLS_SUSPEND;
         OP_WRITE_STATUS_CONFIG: begin
            dif.cls   = SFD_CLS_REGACC;
            dif.nv_pe = 1'b1;
         end
         OP_BOOT_REG_WRITE, OP_NONVOLATILE_LEARNING_PROG: begin
            dif.cls   = SFD_CLS_REGACC;
            dif.nv_pe = 1'b1;
         end
         OP_WRITE_DISABLE, OP_STATUS1_READ, OP_WRITE_ENABLE,
         OP_STATUS2_READ, OP_BOOT_REG_READ, OP_BANK_REG_READ,
         OP_BANK_REG_WRITE, OP_CLEAR_STATUS, OP_CONFIG1_READ,
         OP_LEARNING_PATTERN_READBACK, OP_VOLATILE_LEARNING_WRITE,
         OP_BANK_REGISTER_ACCESS: begin
            dif.cls = SFD_CLS_REGACC;
         end
         OP_SECT_PROT_PROGRAM, OP_PASSWORD_PROGRAM: begin
            dif.cls   = SFD_CLS_PROTECT;
            dif.nv_pe = 1'b1;
         end
         OP_SECT_PROT_READ, OP_OTP_PROGRAM, OP_OTP_READ,
         OP_LOCK_BIT_WRITE, OP_LOCK_BIT_READ, OP_DYN_PROT_READ,
         OP_DYN_PROT_WRITE, OP_PERS_PROT_READ, OP_PERS_PROT_PROGRAM,
         OP_PERS_PROT_ERASE, OP_PASSWORD_READ, OP_PASSWORD_UNLOCK: begin
            dif.cls = SFD_CLS_PROTECT;
         end
         OP_LEGACY_MAKER_SIGNATURE, OP_IDENTIFICATION_READ: begin
            dif.cls = SFD_CLS_IDENT;
         end
         OP_ELECTRONIC_SIG_READ: begin
            dif.cls      = SFD_CLS_IDENT;
            dif.rate_mhz = RATE_MHZ_50;
         end
         OP_SOFTWARE_RESET, OP_CONTINUOUS_MODE_EXIT: begin
            dif.cls = SFD_CLS_RESET;
         end
         default: begin
            // Unlisted and reserved codes, the performance-mode code too
            dif.known = 1'b0;
         end
      endcase
      if (dif.opcode == OP_NORMAL_READ ||
          dif.opcode == OP_NORMAL_READ_LONG_ADDR) begin
         dif.rate_mhz = RATE_MHZ_50;
      end
   end

endmodule : sfd_op_table
`default_nettype wire

// ### logic/sfd_opcode_decoder.sv
// Top: serial flash first-byte opcode decoder behind the chip pins
`default_nettype none
module sfd_opcode_decoder
   import sfd_pkg::*;
(
   input  wire logic          mclk,          // System clock, 125 MHz
   input  wire logic          rst_n,         // Async reset, active low
   input  wire logic          cs_n_pin,      // Chip select pin, active low
   input  wire logic          sck_pin,       // Serial clock pin
   input  wire logic          io0_pin,       // Data line 0, first quad
   input  wire logic          io4_pin,       // Data line 4, second quad
   input  wire logic          cont_mode,     // Continuous read mode active
   output var  logic          cmd_valid,     // Accepted opcode, pulse
   output var  logic [7:0]    cmd_opcode,    // Last opcode received
   output var  sfd_pkg::sfd_class_e cmd_class, // Class of accepted opcode
   output var  logic          addr_long,     // Address fixed at 4 bytes
   output var  logic [7:0]    rate_max_mhz,  // Highest allowed clock, MHz
   output var  logic          nv_array_pe,   // Whole NV array PE cycle
   output var  logic          clr_status,    // Clear fail flags, pulse
   output var  logic          cmd_ignored,   // Unknown opcode, pulse
   output var  logic          cont_exit,     // Continuous mode left, pulse
   output var  logic          cont_addr      // Continuous read resumed
);
   import sfd_pkg::*;

   // ********************************************************************
   // Pin synchronisers
   // ********************************************************************
   typedef enum logic [4:0] {
      SFD_ST_IDLE = 5'h01,
      SFD_ST_OPC  = 5'h02,
      SFD_ST_DEC  = 5'h04,
      SFD_ST_WAIT = 5'h08,
      SFD_ST_CONT = 5'h10
   } sfd_state_e;

   // Synchronisers leave reset at the idle pin levels, so neither a
   // false select nor a false clock edge follows reset
   localparam logic [3:0] PIN_IDLE   = 4'hF;
   localparam logic [7:0] BYTE_CLEAR = 8'h00;

   logic [3:0] meta_ff;
   logic [3:0] sync_ff;
   logic [3:0] nxt_meta;
   logic [3:0] nxt_sync;
   logic       sck_prev_ff;
   logic       nxt_sck_prev;
   logic       cs_n_s;
   logic       sck_s;
   logic       io0_s;
   logic       io4_s;
   logic       sck_rise;

   always_comb begin
      nxt_meta     = {cs_n_pin, sck_pin, io0_pin, io4_pin};
      nxt_sync     = meta_ff;
      nxt_sck_prev = sync_ff[2];
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff     <= PIN_IDLE;
         sync_ff     <= PIN_IDLE;
         sck_prev_ff <= 1'b1;
      end else begin
         meta_ff     <= nxt_meta;
         sync_ff     <= nxt_sync;
         sck_prev_ff <= nxt_sck_prev;
      end
   end

   assign cs_n_s = sync_ff[3];
   assign sck_s  = sync_ff[2];
   assign io0_s  = sync_ff[1];
   assign io4_s  = sync_ff[0];
   // Modes 0 and 3 both sample on the rising edge; sampling limits the
   // usable serial clock to well below a quarter of mclk
   assign sck_rise = sck_s & ~sck_prev_ff;

   // ********************************************************************
   // Opcode lookup
   // ********************************************************************
   sfd_dec_if dif ();

   sfd_op_table u_table (
      .dif (dif)
   );

   // ********************************************************************
   // Frame state machine
   // ********************************************************************
   sfd_state_e state_ff;
   sfd_state_e nxt_state;
   logic [7:0] shift_ff;
   logic [7:0] nxt_shift;
   logic [2:0] cnt_ff;
   logic [2:0] nxt_cnt;

   // Table answers at once from the shift register, but it is only
   // believed in the decode cycle, once all eight bits are in
   assign dif.opcode = shift_ff;

   always_comb begin
      nxt_state = state_ff;
      nxt_shift = shift_ff;
      nxt_cnt   = cnt_ff;
      unique case (state_ff)
         SFD_ST_IDLE: begin
            if (!cs_n_s) begin
               nxt_cnt   = CNT_ZERO;
               nxt_shift = BYTE_CLEAR;
               // Continuous mode is judged once, as the frame opens
               nxt_state = cont_mode ? SFD_ST_CONT : SFD_ST_OPC;
            end
         end
         SFD_ST_OPC: begin
            if (sck_rise) begin
               nxt_shift = {shift_ff[6:0], io0_s};
               nxt_cnt   = cnt_ff + CNT_STEP;
               if (cnt_ff == OPC_LAST_BIT) begin
                  nxt_state = SFD_ST_DEC;
               end
            end
         end
         SFD_ST_DEC: begin
            nxt_state = SFD_ST_WAIT;
         end
         SFD_ST_WAIT: begin
            // Rest of frame belongs to the command sequencer
            nxt_state = state_ff;
         end
         SFD_ST_CONT: begin
            // Count ones up to the eighth; any zero ends the check
            if (sck_rise) begin
               nxt_cnt = cnt_ff + CNT_STEP;
               if (!(io0_s && io4_s)) begin
                  nxt_state = SFD_ST_WAIT;
               end else if (cnt_ff == EXIT_LAST_CYC) begin
                  nxt_state = SFD_ST_WAIT;
               end
            end
         end
      endcase
      // Select rising always ends the frame, whatever the state
      if (cs_n_s) begin
         nxt_state = SFD_ST_IDLE;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= SFD_ST_IDLE;
         shift_ff <= BYTE_CLEAR;
         cnt_ff   <= CNT_ZERO;
      end else begin
         state_ff <= nxt_state;
         shift_ff <= nxt_shift;
         cnt_ff   <= nxt_cnt;
      end
   end

   // ********************************************************************
   // Registered outputs
   // ********************************************************************
   logic       cmd_valid_ff;
   logic       nxt_cmd_valid;
   logic [7:0] cmd_opcode_ff;
   logic [7:0] nxt_cmd_opcode;
   sfd_class_e cmd_class_ff;
   sfd_class_e nxt_cmd_class;
   logic       addr_long_ff;
   logic       nxt_addr_long;
   logic [7:0] rate_ff;
   logic [7:0] nxt_rate;
   logic       nv_pe_ff;
   logic       nxt_nv_pe;
   logic       clr_status_ff;
   logic       nxt_clr_status;
   logic       ignored_ff;
   logic       nxt_ignored;
   logic       cont_exit_ff;
   logic       nxt_cont_exit;
   logic       cont_addr_ff;
   logic       nxt_cont_addr;
   logic       dec_now;
   logic       cont_edge;

   // A select rising in the decode cycle drops the command rather
   // than launching half of it
   assign dec_now   = (state_ff == SFD_ST_DEC) && !cs_n_s;
   assign cont_edge = (state_ff == SFD_ST_CONT) && !cs_n_s && sck_rise;

   always_comb begin
      nxt_cmd_valid  = 1'b0;
      nxt_clr_status = 1'b0;
      nxt_ignored    = 1'b0;
      nxt_cont_exit  = 1'b0;
      nxt_nv_pe      = 1'b0;
      nxt_cmd_opcode = cmd_opcode_ff;
      nxt_cmd_class  = cmd_class_ff;
      nxt_addr_long  = addr_long_ff;
      nxt_rate       = rate_ff;
      nxt_cont_addr  = cont_addr_ff;
      // Resumed-read flag lives for one frame only
      if (state_ff == SFD_ST_IDLE) begin
         nxt_cont_addr = 1'b0;
      end
      if (dec_now) begin
         // Opcode kept even when unknown, for the sequencer to log
         nxt_cmd_opcode = shift_ff;
         if (dif.known) begin
            nxt_cmd_valid = 1'b1;
            nxt_cmd_class = dif.cls;
            nxt_addr_long = dif.long_addr;
            nxt_rate      = dif.rate_mhz;
            nxt_nv_pe     = dif.nv_pe;
            nxt_clr_status = (shift_ff == OP_CLEAR_STATUS);
         end else begin
            // Nothing is launched; device stays in standby
            nxt_ignored   = 1'b1;
            nxt_cmd_class = SFD_CLS_NONE;
            nxt_addr_long = 1'b0;
         end
      end
      // Exit needs eight ones in a row; a single zero turns the frame
      // into a resumed read instead
      if (cont_edge) begin
         if (!(io0_s && io4_s)) begin
            // Frame is a further continuous read; address is on the lines
            nxt_cont_addr = 1'b1;
         end else if (cnt_ff == EXIT_LAST_CYC) begin
            nxt_cont_exit = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_valid_ff  <= 1'b0;
         cmd_opcode_ff <= BYTE_CLEAR;
         cmd_class_ff  <= SFD_CLS_NONE;
         addr_long_ff  <= 1'b0;
         rate_ff       <= RATE_MHZ_133;
         nv_pe_ff      <= 1'b0;
         clr_status_ff <= 1'b0;
         ignored_ff    <= 1'b0;
         cont_exit_ff  <= 1'b0;
         cont_addr_ff  <= 1'b0;
      end else begin
         cmd_valid_ff  <= nxt_cmd_valid;
         cmd_opcode_ff <= nxt_cmd_opcode;
         cmd_class_ff  <= nxt_cmd_class;
         addr_long_ff  <= nxt_addr_long;
         rate_ff       <= nxt_rate;
         nv_pe_ff      <= nxt_nv_pe;
         clr_status_ff <= nxt_clr_status;
         ignored_ff    <= nxt_ignored;
         cont_exit_ff  <= nxt_cont_exit;
         cont_addr_ff  <= nxt_cont_addr;
      end
   end

   // ********************************************************************
   // Output drive
   // ********************************************************************
   // Every output is a flop, so nothing combinational reaches a pin
   assign cmd_valid    = cmd_valid_ff;
   assign cmd_opcode   = cmd_opcode_ff;
   assign cmd_class    = cmd_class_ff;
   assign addr_long    = addr_long_ff;
   assign rate_max_mhz = rate_ff;
   assign nv_array_pe  = nv_pe_ff;
   assign clr_status   = clr_status_ff;
   assign cmd_ignored  = ignored_ff;
   assign cont_exit    = cont_exit_ff;
   assign cont_addr    = cont_addr_ff;

endmodule : sfd_opcode_decoder
`default_nettype wire

// ### verif/sfd_dec_props.sv
// Checker: cause and timing relations of the decoder outputs
`default_nettype none
module sfd_dec_props
   import sfd_pkg::*;
(
   input wire logic                mclk,         // Clock
   input wire logic                rst_n,        // Reset
   input wire logic                cmd_valid,    // Accept
   input wire logic [7:0]          cmd_opcode,   // Opcode
   input wire sfd_pkg::sfd_class_e cmd_class,    // Class
   input wire logic                addr_long,    // Long addr
   input wire logic [7:0]          rate_max_mhz, // Rate
   input wire logic                nv_array_pe,  // NV cycle
   input wire logic                clr_status,   // Clear
   input wire logic                cmd_ignored,  // Ignore
   input wire logic                cont_exit     // Exit
);
   timeunit 1ns;
   timeprecision 1ps;
   // ***********
   // Properties
   // ***********
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   a_valid_one_cycle: assert property (cmd_valid |=> !cmd_valid)
      else $error("valid too wide");
   a_pulse_excl: assert property (!(cmd_valid && cmd_ignored))
      else $error("valid with ignore");
   a_clr_cause: assert property
      (clr_status == (cmd_valid && cmd_opcode == 8'h30)) else $error("clear");
   a_nv_cause: assert property (nv_array_pe == (cmd_valid &&
      cmd_opcode inside {8'h01, 8'h15, 8'h43, 8'h2F, 8'hE8}))
      else $error("nv cycle");
   a_rsvd_never: assert property
      (cmd_valid |-> !(cmd_opcode inside {8'hA3, 8'hE5, 8'hE6}))
      else $error("reserved accepted");
   a_long_flag: assert property (cmd_valid |-> addr_long ==
      (cmd_opcode inside {8'h0C, 8'h12, 8'h13, 8'h21, 8'h34, 8'h6C,
      8'hDC, 8'hEC, 8'hEE})) else $error("long flag");
   a_erase_class: assert property (cmd_valid && cmd_opcode inside
      {8'h20, 8'h21, 8'h60, 8'hC7, 8'hD8, 8'hDC} |->
      cmd_class == SFD_CLS_ERASE) else $error("erase class");
   a_quad_rate: assert property (cmd_valid && cmd_opcode inside
      {8'h6B, 8'h6C, 8'hEB, 8'hEC} |-> rate_max_mhz == 8'h68)
      else $error("quad rate");
   a_exit_once: assert property
      (cont_exit |-> !cmd_valid ##1 !cont_exit) else $error("exit pulse");
endmodule : sfd_dec_props
`default_nettype wire

// ### verif/sfd_host_model.sv
// Host model: drives one opcode frame on the pins
`default_nettype none
module sfd_host_model (
   input  wire logic mclk, // System clock
   output var  logic cs_n, // Select, active low
   output var  logic sck,  // Serial clock
   output var  logic io0,  // Data line 0
   output var  logic io4   // Data line 4
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      io0 = 1'b0;
      io4 = 1'b0;
   end
   // Twelve mclk per sck period keeps every opcode far below its limit
   task automatic frame(input logic [7:0] op, input int nb, input logic hi);
      repeat (4) @(posedge mclk);
      cs_n <= 1'b0;
      for (int i = 0; i < nb; i++) begin
         repeat (4) @(posedge mclk);
         io0 <= op[7 - i]; // MSB first; ones on both for exit
         io4 <= hi;
         repeat (4) @(posedge mclk);
         sck <= 1'b1;
         repeat (4) @(posedge mclk);
         sck <= 1'b0;
      end
      repeat (4) @(posedge mclk);
      cs_n <= 1'b1;
      io0 <= ~io0; // Released lines must not keep a stale bit
      io4 <= ~io4;
      repeat (8) @(posedge mclk);
   endtask : frame
endmodule : sfd_host_model
`default_nettype wire

// ### verif/sfd_opcode_decoder_tb.sv
// Testbench: opcode decoder scenarios
`default_nettype none
module sfd_opcode_decoder_tb;
   import sfd_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0, rst_n = 1'b0, cont_mode = 1'b0;
   logic cs_n, sck, io0, io4, cmd_valid, addr_long, nv_array_pe, clr_status;
   logic cmd_ignored, cont_exit, cont_addr;
   logic [7:0] cmd_opcode, rate_max_mhz;
   sfd_class_e cmd_class;
   logic [23:0] d;
   int errors = 0, n_tests = 0, n_v = 0, n_i = 0, n_x = 0, n_a = 0;
   // Opcode, class, long flag, rate
   localparam logic [23:0] TBL [27] = '{24'h022085, 24'h122185,
      24'h031032, 24'h131132, 24'h0B1085, 24'h0C1185, 24'h203085, 24'h213185,
      24'h322050, 24'h382050, 24'h342150, 24'h603085, 24'hC73085, 24'h6B1068,
      24'h6C1168, 24'h907085, 24'h9F7085, 24'hB95085, 24'hD83085, 24'hDC3185,
      24'hEB1068, 24'hEC1168, 24'hED1050, 24'hEE1150, 24'h4A5085, 24'h415085,
      24'h305085};
   // Reserved codes and one unlisted code
   localparam logic [7:0] IGN [4] = '{8'hA3, 8'hE5, 8'hE6, 8'h77};
   always #4 mclk = ~mclk;
   always @(posedge mclk) begin
      n_v <= n_v + (cmd_valid === 1'b1);
      n_i <= n_i + (cmd_ignored === 1'b1);
      n_x <= n_x + (cont_exit === 1'b1);
      n_a <= n_a + (cont_addr === 1'b1);
   end
   sfd_host_model sfd_host_model_i (.mclk, .cs_n, .sck, .io0, .io4);
   sfd_opcode_decoder sfd_opcode_decoder_i (.mclk, .rst_n, .cs_n_pin(cs_n),
      .sck_pin(sck), .io0_pin(io0), .io4_pin(io4), .cont_mode, .cmd_valid,
      .cmd_opcode, .cmd_class, .addr_long, .rate_max_mhz, .nv_array_pe,
      .clr_status, .cmd_ignored, .cont_exit, .cont_addr);
   task automatic chk(input logic [23:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // Pulse counts seen during one frame
   task automatic run(input logic [7:0] op, input int nb, input logic hi);
      int v0 = n_v, i0 = n_i, x0 = n_x;
      sfd_host_model_i.frame(op, nb, hi);
      d = {8'(n_v - v0), 8'(n_i - i0), 8'(n_x - x0)};
   endtask : run
   task automatic t_table;
      foreach (TBL[k]) begin
         run(TBL[k][23:16], 8, 1'b0);
         chk(d, 24'h010000);
         chk(cmd_opcode, TBL[k][23:16]);
         chk(cmd_class, TBL[k][15:12]);
         chk(addr_long, TBL[k][8]);
         chk(rate_max_mhz, TBL[k][7:0]);
      end
      $display("table done");
   endtask : t_table
   task automatic t_ignore;
      foreach (IGN[k]) begin
         run(IGN[k], 8, 1'b0);
         chk(d, 24'h000100);
         chk({cmd_opcode, cmd_class}, {IGN[k], SFD_CLS_NONE});
      end
      run(8'h02, 5, 1'b0);
      chk(d, 24'h000000);
      $display("ignore done");
   endtask : t_ignore
   task automatic t_nvw;
      run(8'h01, 8, 1'b0);
      chk(d, 24'h010000);
      chk({cmd_class, rate_max_mhz}, {SFD_CLS_REGACC, 8'h85});
      run(8'h43, 8, 1'b0);
      chk(d, 24'h010000);
      chk(cmd_class, SFD_CLS_REGACC);
      $display("nv write done");
   endtask : t_nvw
   task automatic t_exit;
      int a0;
      @(posedge mclk);
      cont_mode <= 1'b1;
      run(8'hFF, 8, 1'b1);
      chk(d, 24'h000001);
      a0 = n_a;
      run(8'h00, 8, 1'b0);
      chk(d, 24'h000000);
      chk({n_a != a0, cont_addr}, 2'b10);
      cont_mode <= 1'b0;
      $display("exit done");
   endtask : t_exit
   task automatic wrap_up;
      $display("tests %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      chk({cmd_class, rate_max_mhz}, {SFD_CLS_NONE, 8'h85});
      t_table;
      t_ignore;
      t_nvw;
      t_exit;
      wrap_up;
   end
   initial begin
      #200us;
      errors++;
      wrap_up;
   end
endmodule : sfd_opcode_decoder_tb
bind sfd_opcode_decoder sfd_dec_props sfd_dec_props_i (.mclk, .rst_n,
   .cmd_valid, .cmd_opcode, .cmd_class, .addr_long, .rate_max_mhz,
   .nv_array_pe, .clr_status, .cmd_ignored, .cont_exit);
`default_nettype wire
